// [rtl/timing_path_freq_config.sv]
// timing path frequency configuration: registers, path control outputs and phase meter
`timescale 1ns/100ps

// Behaviour
// - phase meter bit disables secondary dpll
// - secondary detector measures main versus secondary input
// - bit clear keeps secondary path normal
// - bit 6 selects secondary apll feed source
// - codes 010/011 give 12E1 and 16E1 rates
// - codes 100/101 give 24DS1 and 16DS1 rates
module timing_path_freq_config
(
    input wire logic clock, // 250 MHz core clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic [7:0] regAddr, // register address
    input wire logic regWrEn, // write strobe, one cycle
    input wire logic [7:0] regWrData, // write data
    input wire logic regRdEn, // read strobe, one cycle
    output logic [7:0] regRdData, // read data, valid the cycle after regRdEn
    input wire logic mainRefEdge, // edge pulse of selected main-path input
    input wire logic secRefEdge, // edge pulse of selected secondary-path input
    output logic secondaryDpllEn, // secondary dpll tracking enabled
    output logic phaseMeterActive, // secondary detector repurposed as phase meter
    output logic secondaryApllFromMain, // secondary apll fed by main dpll
    output logic [2:0] mainDpllRate, // main dpll rate code in force
    output logic mainAnalogFeedback, // main dpll uses analog feedback
    output logic [18:0] mainApllKhz, // main apll frequency in kHz
    output logic [18:0] secondaryApllKhz, // secondary apll frequency in kHz, 0 when own dpll feeds it
    output logic mainRateLegal, // main rate code is a defined one
    output logic [1:0] secondaryDpllLoopBw, // secondary dpll bandwidth code
    output logic [15:0] phaseDiff, // clocks from main edge to secondary edge, minus one; saturates at ffff
    output logic phaseDiffValid // one-cycle pulse on a new measurement
);

    // ==========================================================
    // configuration registers
    logic [7:0] pathCfg_ff;
    logic [7:0] bwCfg_ff;
    logic [7:0] rdData_ff;
    logic wrPath;
    logic wrBw;

    assign wrPath = regWrEn && (regAddr == tpfc_pkg::ADDR_PATH_CFG);
    assign wrBw = regWrEn && (regAddr == tpfc_pkg::ADDR_BW_CFG);

    // all bits are stored as written so software reads back its own value
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pathCfg_ff <= tpfc_pkg::RST_PATH_CFG;
        end
        else if (wrPath)
        begin
            pathCfg_ff <= regWrData;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bwCfg_ff <= tpfc_pkg::RST_BW_CFG;
        end
        else if (wrBw)
        begin
            bwCfg_ff <= regWrData;
        end
    end

    // ==========================================================
    // read port
    logic [7:0] nxt_rdData;

    always_comb
    begin
        case (regAddr)
            tpfc_pkg::ADDR_PATH_CFG: nxt_rdData = pathCfg_ff;
            tpfc_pkg::ADDR_BW_CFG: nxt_rdData = bwCfg_ff;
            default: nxt_rdData = tpfc_pkg::RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdData_ff <= tpfc_pkg::RD_UNMAPPED;
        end
        else if (regRdEn)
        begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;

    // ==========================================================
    // rate decoding
    tpfc_cfg_if cfgBus ();

    assign cfgBus.mainRate = pathCfg_ff[tpfc_pkg::POS_MAIN_RATE_HI:tpfc_pkg::POS_MAIN_RATE_LO];
    assign cfgBus.secRate = pathCfg_ff[tpfc_pkg::POS_SEC_RATE_HI:tpfc_pkg::POS_SEC_RATE_LO];
    assign cfgBus.apllFromMain = pathCfg_ff[tpfc_pkg::BIT_APLL_SRC];

    tpfc_rate_decode uDecode
    (
        .cfg(cfgBus)
    );

    // ==========================================================
    // path control outputs, registered one cycle behind the register write
    logic secDpllEn_ff;
    logic meterOn_ff;
    logic apllFromMain_ff;
    logic [2:0] mainRate_ff;
    logic analogFb_ff;
    logic [18:0] mainKhz_ff;
    logic [18:0] secKhz_ff;
    logic legal_ff;
    logic [1:0] loopBw_ff;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            secDpllEn_ff <= 1'b1;
            meterOn_ff <= 1'b0;
        end
        else
        begin
            secDpllEn_ff <= !pathCfg_ff[tpfc_pkg::BIT_PHASE_METER];
            meterOn_ff <= pathCfg_ff[tpfc_pkg::BIT_PHASE_METER];
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            apllFromMain_ff <= 1'b0;
            mainRate_ff <= tpfc_pkg::RATE_7776_DIG;
            analogFb_ff <= 1'b0;
            mainKhz_ff <= tpfc_pkg::KHZ_311040;
            secKhz_ff <= tpfc_pkg::KHZ_NONE;
            legal_ff <= 1'b1;
        end
        else
        begin
            apllFromMain_ff <= cfgBus.apllFromMain;
            mainRate_ff <= cfgBus.mainRate;
            analogFb_ff <= cfgBus.mainAnalogFb;
            mainKhz_ff <= cfgBus.mainApllKhz;
            secKhz_ff <= cfgBus.secApllKhz;
            legal_ff <= cfgBus.mainRateLegal;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            loopBw_ff <= 2'h0;
        end
        else
        begin
            loopBw_ff <= bwCfg_ff[tpfc_pkg::POS_BW_HI:tpfc_pkg::POS_BW_LO];
        end
    end

    assign secondaryDpllEn = secDpllEn_ff;
    assign phaseMeterActive = meterOn_ff;
    assign secondaryApllFromMain = apllFromMain_ff;
    assign mainDpllRate = mainRate_ff;
    assign mainAnalogFeedback = analogFb_ff;
    assign mainApllKhz = mainKhz_ff;
    assign secondaryApllKhz = secKhz_ff;
    assign mainRateLegal = legal_ff;
    assign secondaryDpllLoopBw = loopBw_ff;

    // ==========================================================
    // phase meter: count from a main edge to the next secondary edge
    tpfc_pkg::tpfc_pm_state_t pmState_ff;
    logic [15:0] phCount_ff;
    logic [15:0] phDiff_ff;
    logic phValid_ff;

    // a secondary edge with no main edge before it is ignored; counter saturates
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pmState_ff <= tpfc_pkg::TPFC_PM_IDLE;
        end
        else if (!meterOn_ff)
        begin
            pmState_ff <= tpfc_pkg::TPFC_PM_IDLE;
        end
        else
        begin
            case (pmState_ff)
                tpfc_pkg::TPFC_PM_IDLE:
                begin
                    if (mainRefEdge && !secRefEdge)
                    begin
                        pmState_ff <= tpfc_pkg::TPFC_PM_RUN;
                    end
                end
                tpfc_pkg::TPFC_PM_RUN:
                begin
                    if (secRefEdge)
                    begin
                        pmState_ff <= tpfc_pkg::TPFC_PM_IDLE;
                    end
                end
                default: pmState_ff <= tpfc_pkg::TPFC_PM_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            phCount_ff <= tpfc_pkg::PH_ZERO;
        end
        else if (pmState_ff == tpfc_pkg::TPFC_PM_RUN && phCount_ff != tpfc_pkg::PH_MAX)
        begin
            phCount_ff <= phCount_ff + 16'h0001;
        end
        else if (pmState_ff == tpfc_pkg::TPFC_PM_IDLE)
        begin
            phCount_ff <= tpfc_pkg::PH_ZERO;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            phDiff_ff <= tpfc_pkg::PH_ZERO;
            phValid_ff <= 1'b0;
        end
        else if (meterOn_ff && pmState_ff == tpfc_pkg::TPFC_PM_RUN && secRefEdge)
        begin
            phDiff_ff <= phCount_ff;
            phValid_ff <= 1'b1;
        end
        else
        begin
            phValid_ff <= 1'b0;
        end
    end

    assign phaseDiff = phDiff_ff;
    assign phaseDiffValid = phValid_ff;

endmodule : timing_path_freq_config

// [rtl/tpfc_cfg_if.sv]
// interface carrying configuration fields to the rate decoder and its answers back
`timescale 1ns/100ps
interface tpfc_cfg_if;
    logic [2:0] mainRate;
    logic [1:0] secRate;
    logic apllFromMain;
    logic [18:0] mainApllKhz;
    logic [18:0] secApllKhz;
    logic mainAnalogFb;
    logic mainRateLegal;

    modport src
    (
        output mainRate,
        output secRate,
        output apllFromMain,
        input mainApllKhz,
        input secApllKhz,
        input mainAnalogFb,
        input mainRateLegal
    );

    modport dec
    (
        input mainRate,
        input secRate,
        input apllFromMain,
        output mainApllKhz,
        output secApllKhz,
        output mainAnalogFb,
        output mainRateLegal
    );
endinterface : tpfc_cfg_if

// [rtl/tpfc_pkg.sv]
// package of constants and types for the timing path frequency configuration block
package tpfc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_PATH_CFG = 8'h65;
    localparam logic [7:0] ADDR_BW_CFG = 8'h66;
    localparam logic [7:0] RST_PATH_CFG = 8'h00;
    localparam logic [7:0] RST_BW_CFG = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ==========================================================
    // field positions in the path register and the bandwidth register
    localparam int BIT_PHASE_METER = 7;
    localparam int BIT_APLL_SRC = 6;
    localparam int POS_SEC_RATE_LO = 4;
    localparam int POS_SEC_RATE_HI = 5;
    localparam int POS_MAIN_RATE_LO = 0;
    localparam int POS_MAIN_RATE_HI = 2;
    localparam int POS_BW_LO = 0;
    localparam int POS_BW_HI = 1;

    // ==========================================================
    // main rate codes
    localparam logic [2:0] RATE_7776_DIG = 3'h0;
    localparam logic [2:0] RATE_7776_ANA = 3'h1;
    localparam logic [2:0] RATE_12E1 = 3'h2;
    localparam logic [2:0] RATE_16E1 = 3'h3;
    localparam logic [2:0] RATE_24DS1 = 3'h4;
    localparam logic [2:0] RATE_16DS1 = 3'h5;
    // the secondary rate field maps onto main codes 010..101
    localparam logic [2:0] SEC_RATE_OFFSET = 3'h2;

    // ==========================================================
    // apll frequencies in kHz
    localparam int KHZ_W = 19;
    localparam logic [18:0] KHZ_311040 = 19'h4bf00;
    localparam logic [18:0] KHZ_98304 = 19'h18000;
    localparam logic [18:0] KHZ_131072 = 19'h20000;
    localparam logic [18:0] KHZ_148224 = 19'h24300;
    localparam logic [18:0] KHZ_98816 = 19'h18200;
    localparam logic [18:0] KHZ_NONE = 19'h00000;

    // ==========================================================
    // phase meter
    localparam int PH_W = 16;
    localparam logic [15:0] PH_ZERO = 16'h0000;
    localparam logic [15:0] PH_MAX = 16'hffff;

    typedef enum logic [0:0]
    {
        TPFC_PM_IDLE = 1'h0,
        TPFC_PM_RUN = 1'h1
    } tpfc_pm_state_t;

endpackage : tpfc_pkg

// [rtl/tpfc_rate_decode.sv]
// rate decoder: main and secondary apll frequency from the rate fields
`timescale 1ns/100ps
module tpfc_rate_decode
(
    tpfc_cfg_if.dec cfg // configuration fields in, decoded rates out
);

    // ==========================================================
    // shared rate table, used for both the main field and the secondary field
    function automatic logic [18:0] tpfc_rate_khz(input logic [2:0] code);
        logic [18:0] khz;
        khz = tpfc_pkg::KHZ_NONE;
        case (code)
            tpfc_pkg::RATE_7776_DIG: khz = tpfc_pkg::KHZ_311040;
            tpfc_pkg::RATE_7776_ANA: khz = tpfc_pkg::KHZ_311040;
            tpfc_pkg::RATE_12E1: khz = tpfc_pkg::KHZ_98304;
            tpfc_pkg::RATE_16E1: khz = tpfc_pkg::KHZ_131072;
            tpfc_pkg::RATE_24DS1: khz = tpfc_pkg::KHZ_148224;
            tpfc_pkg::RATE_16DS1: khz = tpfc_pkg::KHZ_98816;
            default: khz = tpfc_pkg::KHZ_NONE;
        endcase
        return khz;
    endfunction : tpfc_rate_khz

    logic [2:0] secCode;

    assign secCode = {1'b0, cfg.secRate} + tpfc_pkg::SEC_RATE_OFFSET;
    assign cfg.mainApllKhz = tpfc_rate_khz(cfg.mainRate);
    assign cfg.mainAnalogFb = (cfg.mainRate == tpfc_pkg::RATE_7776_ANA);
    // codes 110 and 111 are left to software to avoid; flagged, not trapped
    assign cfg.mainRateLegal = (tpfc_rate_khz(cfg.mainRate) != tpfc_pkg::KHZ_NONE);
    // frequency from the secondary dpll is set elsewhere, so only the main feed is known here
    assign cfg.secApllKhz = cfg.apllFromMain ? tpfc_rate_khz(secCode) : tpfc_pkg::KHZ_NONE;

endmodule : tpfc_rate_decode

// [tb/timing_path_freq_config_bench.sv]
// self-checking bench for the timing path frequency configuration block
`timescale 1ns/100ps
module timing_path_freq_config_bench;
    typedef struct packed
    {
        logic [7:0] wd;
        logic [18:0] mk;
        logic [18:0] sk;
        logic fb;
        logic ok;
    } tpfc_row_t;
    // ==========================================================
    // signals and dut
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic mainRefEdge = 1'b0;
    logic secRefEdge = 1'b0;
    logic [7:0] regRdData, rv;
    logic secondaryDpllEn, phaseMeterActive, secondaryApllFromMain, mainAnalogFeedback, mainRateLegal, phaseDiffValid;
    logic [2:0] mainDpllRate;
    logic [18:0] mainApllKhz, secondaryApllKhz;
    logic [1:0] secondaryDpllLoopBw;
    logic [15:0] phaseDiff;
    int errors = 0;
    int n_compared = 0;
    tpfc_row_t rows [8] = '{'{8'h00, 19'h4bf00, 19'h0, 1'b0, 1'b1}, '{8'h41, 19'h4bf00, 19'h18000, 1'b1, 1'b1},
        '{8'h52, 19'h18000, 19'h20000, 1'b0, 1'b1}, '{8'h63, 19'h20000, 19'h24300, 1'b0, 1'b1},
        '{8'h74, 19'h24300, 19'h18200, 1'b0, 1'b1}, '{8'h35, 19'h18200, 19'h0, 1'b0, 1'b1},
        '{8'h0e, 19'h0, 19'h0, 1'b0, 1'b0}, '{8'hc7, 19'h0, 19'h18000, 1'b0, 1'b0}};
    always #2 clock = ~clock;
    timing_path_freq_config dut_u (.clock, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
        .mainRefEdge, .secRefEdge, .secondaryDpllEn, .phaseMeterActive, .secondaryApllFromMain, .mainDpllRate,
        .mainAnalogFeedback, .mainApllKhz, .secondaryApllKhz, .mainRateLegal, .secondaryDpllLoopBw, .phaseDiff,
        .phaseDiffValid);
    // ==========================================================
    // tasks
    task tick;
        @(posedge clock);
        #1;
    endtask : tick
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task finish_test;
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick;
        regWrEn = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        tick;
        regRdEn = 1'b0;
        d = regRdData;
    endtask : rd
    task meas(input int gap, input logic expv);
        int n;
        mainRefEdge = 1'b1;
        tick;
        mainRefEdge = 1'b0;
        repeat (gap - 1) tick;
        secRefEdge = 1'b1;
        tick;
        secRefEdge = 1'b0;
        n = 0;
        while (phaseDiffValid !== 1'b1 && n < 3)
        begin
            tick;
            n++;
        end
        chk("pdDelay", 32'(n), expv ? 32'h0 : 32'h3);
        // a gap beyond the counter range must pin the result at full scale
        if (expv)
            chk("phaseDiff", 32'(phaseDiff), (gap > 65536) ? 32'hffff : 32'(gap - 1));
        if (expv && n == 3)
            finish_test;
    endtask : meas
    // ==========================================================
    // sequence
    initial
    begin
        repeat (5) tick;
        rst = 1'b0;
        rd(8'h65, rv);
        chk("rstPath", 32'(rv), 32'h00);
        foreach (rows[i])
        begin
            wr(8'h65, rows[i].wd);
            rd(8'h65, rv);
            chk("readback", 32'(rv), 32'(rows[i].wd));
            chk("mainKhz", 32'(mainApllKhz), 32'(rows[i].mk));
            chk("secKhz", 32'(secondaryApllKhz), 32'(rows[i].sk));
            chk("feedback", 32'(mainAnalogFeedback), 32'(rows[i].fb));
            chk("legal", 32'(mainRateLegal), 32'(rows[i].ok));
            chk("meter", 32'(phaseMeterActive), 32'(rows[i].wd[7]));
            chk("apllSrc", 32'(secondaryApllFromMain), 32'(rows[i].wd[6]));
            chk("secEn", 32'(secondaryDpllEn), 32'(!rows[i].wd[7]));
            chk("rate", 32'(mainDpllRate), 32'(rows[i].wd[2:0]));
        end
        wr(8'h66, 8'h02);
        rd(8'h66, rv);
        chk("bwReg", 32'(rv), 32'h02);
        chk("loopBw", 32'(secondaryDpllLoopBw), 32'h2);
        wr(8'h67, 8'h5a);
        rd(8'h67, rv);
        chk("unmapped", 32'(rv), 32'h00);
        regWrData = 8'h81;
        regWrEn = 1'b1;
        rd(8'h65, rv);
        regWrEn = 1'b0;
        chk("oldOnClash", 32'(rv), 32'hc7);
        tick;
        meas(3, 1'b1);
        meas(1, 1'b1);
        meas(70000, 1'b1);
        // a secondary edge with nothing armed must not start or end a measurement
        secRefEdge = 1'b1;
        tick;
        secRefEdge = 1'b0;
        chk("strayValid", 32'(phaseDiffValid), 32'h0);
        chk("phaseHold", 32'(phaseDiff), 32'hffff);
        wr(8'h65, 8'h00);
        tick;
        meas(3, 1'b0);
        wr(8'h65, 8'hd3);
        rst = 1'b1;
        tick;
        chk("rstKhz", 32'(mainApllKhz), 32'h4bf00);
        chk("rstSecEn", 32'(secondaryDpllEn), 32'h1);
        rst = 1'b0;
        rd(8'h65, rv);
        chk("rstReg", 32'(rv), 32'h00);
        finish_test;
    end
endmodule : timing_path_freq_config_bench

bind timing_path_freq_config tpfc_chk chk_u (.clock, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
    .secRefEdge, .secondaryDpllEn, .phaseMeterActive, .secondaryApllFromMain, .mainDpllRate, .mainAnalogFeedback,
    .mainApllKhz, .secondaryApllKhz, .phaseDiffValid);

// [tb/tpfc_chk.sv]
// concurrent checks on the timing path frequency configuration ports
`timescale 1ns/100ps
module tpfc_chk
(
    input wire logic clock, // core clock
    input wire logic rst, // async reset
    input wire logic [7:0] regAddr, // address
    input wire logic regWrEn, // write strobe
    input wire logic [7:0] regWrData, // write data
    input wire logic regRdEn, // read strobe
    input wire logic [7:0] regRdData, // read data
    input wire logic secRefEdge, // secondary edge
    input wire logic secondaryDpllEn, // dpll enable
    input wire logic phaseMeterActive, // meter mode
    input wire logic secondaryApllFromMain, // apll source
    input wire logic [2:0] mainDpllRate, // rate code
    input wire logic mainAnalogFeedback, // feedback type
    input wire logic [18:0] mainApllKhz, // main apll
    input wire logic [18:0] secondaryApllKhz, // secondary apll
    input wire logic phaseDiffValid // new measurement
);
    logic wr65;
    assign wr65 = regWrEn && regAddr == 8'h65;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // write lands on edge 0, decoded outputs follow one edge later
    property p_pm_off;
        wr65 |-> ##2 secondaryDpllEn == !$past(regWrData[7], 2);
    endproperty
    a_pm_off: assert property (p_pm_off) else $error("dpll enable mismatch");
    // a cleared meter bit must bring back tracking and drop the meter
    property p_pm_mode;
        wr65 && !regWrData[7] |-> ##2 secondaryDpllEn && !phaseMeterActive;
    endproperty
    a_pm_mode: assert property (p_pm_mode) else $error("meter and dpll both on");
    property p_meas;
        phaseDiffValid |-> $past(phaseMeterActive) && $past(secRefEdge);
    endproperty
    a_meas: assert property (p_meas) else $error("stray measurement");
    property p_src;
        wr65 |-> ##2 secondaryApllFromMain == $past(regWrData[6], 2);
    endproperty
    a_src: assert property (p_src) else $error("apll source mismatch");
    property p_sec;
        wr65 && regWrData[6:4] == 3'h7 |-> ##2 secondaryApllKhz == 19'h18200;
    endproperty
    a_sec: assert property (p_sec) else $error("secondary rate mismatch");
    property p_fb;
        mainAnalogFeedback == (mainDpllRate == 3'h1);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback type mismatch");
    property p_e1;
        mainDpllRate == 3'h3 |-> mainApllKhz == 19'h20000;
    endproperty
    a_e1: assert property (p_e1) else $error("16E1 rate mismatch");
    property p_ds1;
        mainDpllRate == 3'h4 |-> mainApllKhz == 19'h24300;
    endproperty
    a_ds1: assert property (p_ds1) else $error("24DS1 rate mismatch");
    property p_rd;
        wr65 ##1 (regRdEn && regAddr == 8'h65 && !regWrEn) |=> regRdData == $past(regWrData, 2);
    endproperty
    a_rd: assert property (p_rd) else $error("readback mismatch");
endmodule : tpfc_chk
